/* src/channel_number_irq_consts.vh */
/*
 * Constants for the channel interrupt vector builder and mailbox FIFO:
 * register offsets, vector field positions and codes, reset values.
 * Assumes inclusion by the single design file of the block.
 */
// How it works
// - Tx vector bits 21:16 carry descriptor tag.
// - Bit 15 marks finished host-initiated descriptor.
// - Bit 14 marks abort command or incomplete frame.
// - Bit 12 hold abort, sent after data done.
// - Hold abort also asks engine to append abort.
// - Bits 7:0 carry the channel number.
// - Command vectors go to queue eight.
// - Command vector 1/0010, bit 17 allocation failure.
// - Either threshold above buffer size also fails.
// - Bit 16 marks successful init or off.
// - Mailbox vectors queue in FIFO, two readers.
// - Local interrupt high while FIFO holds vectors.
// - Host mailbox write makes vector, bits 6:0 fixed.
// - Bits 13:7 copy message, bit 14 zero.
// - Bit 15 computed at read: last one.
`ifndef CHANNEL_NUMBER_IRQ_CONSTS_VH
`define CHANNEL_NUMBER_IRQ_CONSTS_VH

// ====================================================================
// Register map (byte addresses, APB).
`define REG_MBOX_STATUS 12'h000
`define REG_IRQ_FIFO 12'h004
`define REG_FIFO_LEVEL 12'h008
`define REG_IRQ_STATUS 12'h00c
`define REG_IRQ_MASK 12'h010
`define IRQ_MASK_RESET 4'h0

// ====================================================================
// Interrupt status bit positions.
`define ST_MBOX_PUSH 0
`define ST_FIFO_OVFL 1
`define ST_CMD_FAIL 2
`define ST_VEC_DROP 3

// ====================================================================
// Vector fields.
`define VEC_TYPE_BIT 31
`define TXEV_TYPE 4'h7
`define CMD_TX_TYPE 4'h2
`define CMD_QUEUE 4'h8
`define TAG_LSB 16
`define HOST_INIT_BIT 15
`define ABORT_BIT 14
`define HOLD_ABORT_BIT 12
`define CMD_FAIL_BIT 17
`define CMD_DONE_BIT 16
`define MB_LAST_BIT 15
`define MB_MSG_LSB 7
`define MB_FIXED 7'h60

// ====================================================================
// Transmit command codes and FIFO size.
`define TXCMD_INIT 2'h1
`define TXCMD_OFF 2'h2
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

/* src/channel_number_irq_vectors.v */
/*
 * Interrupt vector builder: transmit event vectors, transmit command
 * vectors for the command queue, and the mailbox interrupt FIFO with its
 * local interrupt line and APB register file.
 * Assumes event inputs are synchronous single-cycle pulses from the
 * channel engine and the local read strobe is an asynchronous pin.
 */
`timescale 1ns/100ps
`include "channel_number_irq_consts.vh"

module channel_number_irq_vectors (
    // Clock, reset and enable
    input wire i_core_clk,
    input wire i_resetn,
    input wire i_clk_en,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // Transmit descriptor events
    input wire i_tx_evt,
    input wire [7:0] i_tx_channel_number,
    input wire [2:0] i_tx_queue,
    input wire [5:0] i_tx_descriptor_tag,
    input wire i_tx_host_initiated_flag,
    input wire i_tx_abort_cmd,
    input wire i_tx_next_offset_zero,
    input wire i_tx_frame_end_flag,
    input wire i_tx_prev_incomplete,
    input wire i_tx_fetch,
    input wire i_tx_fetch_hold,
    input wire i_tx_fetch_frame_end_flag,
    input wire i_tx_data_done,
    output reg o_append_abort,
    // Transmit command completion
    input wire i_cmd_valid,
    input wire [1:0] i_tx_command_field,
    input wire [7:0] i_cmd_channel_number,
    input wire [15:0] i_alloc_req,
    input wire [15:0] i_alloc_avail,
    input wire [15:0] i_fwd_thr,
    input wire [15:0] i_refill_thr,
    input wire [15:0] i_buf_size,
    // Vector output towards the interrupt queues
    output reg o_vec_valid,
    output reg [31:0] o_vec_data,
    output reg [3:0] o_vec_queue,
    // Local microprocessor side
    input wire i_local_rd_n,
    output reg [15:0] o_local_data,
    output reg o_local_interrupt_out,
    output reg o_irq
);

    // ====================================================================
    // Local read strobe synchroniser.
    reg rd_s1_r;
    reg rd_s2_r;
    reg rd_s3_r;

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_s1_r <= 1'b1;
            rd_s2_r <= 1'b1;
            rd_s3_r <= 1'b1;
        end else if (i_clk_en) begin
            rd_s1_r <= i_local_rd_n;
            rd_s2_r <= rd_s1_r;
            rd_s3_r <= rd_s2_r;
        end
    end

    wire local_rd_fall = rd_s3_r & ~rd_s2_r;

    // ====================================================================
    // Mailbox FIFO storage.
    reg [6:0] fifo_mem_r [0:`FIFO_DEPTH-1];
    reg [`FIFO_AW-1:0] wr_ptr_r;
    reg [`FIFO_AW-1:0] rd_ptr_r;
    reg [`FIFO_AW:0] level_r;
    reg [`FIFO_AW:0] level_nxt;
    reg [6:0] last_msg_r;
    reg local_pend_r;
    reg [3:0] irq_status_r;
    reg [3:0] irq_status_nxt;
    reg [3:0] irq_mask_r;
    reg hold_pend_r;
    reg [7:0] hold_channel_number_r;
    reg [2:0] hold_queue_r;
    reg [5:0] hold_tag_r;

    wire fifo_empty = (level_r == {(`FIFO_AW+1){1'b0}});
    wire fifo_full = (level_r == `FIFO_DEPTH);

    // Vector at the head, LAST computed at read time.
    wire head_last = (level_r == {{`FIFO_AW{1'b0}}, 1'b1});
    wire [15:0] head_vec = fifo_empty ? 16'h0000 :
        {head_last, 1'b0, fifo_mem_r[rd_ptr_r], `MB_FIXED};

    // ====================================================================
    // APB decode; no wait state, read data is registered in the setup phase so it comes from a flop.
    wire apb_setup = i_psel & ~i_penable;
    wire apb_fire = i_psel & i_penable & o_pready;
    wire apb_wr = apb_fire & i_pwrite;
    wire addr_ok = (i_paddr == `REG_MBOX_STATUS) | (i_paddr == `REG_IRQ_FIFO) |
                   (i_paddr == `REG_FIFO_LEVEL) | (i_paddr == `REG_IRQ_STATUS) |
                   (i_paddr == `REG_IRQ_MASK);

    wire mbox_push = apb_wr & (i_paddr == `REG_MBOX_STATUS);
    wire apb_pop = apb_fire & ~i_pwrite & (i_paddr == `REG_IRQ_FIFO) & ~fifo_empty;
    wire local_pop = (local_rd_fall | local_pend_r) & ~apb_pop & ~fifo_empty;
    wire do_pop = apb_pop | local_pop;
    wire do_push = mbox_push & ~fifo_full;

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
        end else if (i_clk_en) begin
            if (apb_setup) begin
                o_pready <= 1'b1;
                o_pslverr <= ~addr_ok;
                case (i_paddr)
                    `REG_MBOX_STATUS: o_prdata <= {25'h0000000, last_msg_r};
                    `REG_IRQ_FIFO: o_prdata <= {16'h0000, head_vec};
                    `REG_FIFO_LEVEL: o_prdata <= {28'h0000000, level_r};
                    `REG_IRQ_STATUS: o_prdata <= {28'h0000000, irq_status_r};
                    `REG_IRQ_MASK: o_prdata <= {28'h0000000, irq_mask_r};
                    default: o_prdata <= 32'h00000000;
                endcase
            end else begin
                o_pready <= 1'b0;
                o_pslverr <= 1'b0;
            end
        end
    end

    // ====================================================================
    // FIFO pointers, level and local read path.
    always @* begin
        level_nxt = level_r;
        if (do_push & ~do_pop) begin
            level_nxt = level_r + {{`FIFO_AW{1'b0}}, 1'b1};
        end else if (do_pop & ~do_push) begin
            level_nxt = level_r - {{`FIFO_AW{1'b0}}, 1'b1};
        end
    end

    integer i;

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_r <= {`FIFO_AW{1'b0}};
            rd_ptr_r <= {`FIFO_AW{1'b0}};
            level_r <= {(`FIFO_AW+1){1'b0}};
            last_msg_r <= 7'h00;
            local_pend_r <= 1'b0;
            o_local_data <= 16'h0000;
            o_local_interrupt_out <= 1'b0;
            for (i = 0; i < `FIFO_DEPTH; i = i + 1) begin
                fifo_mem_r[i] <= 7'h00;
            end
        end else if (i_clk_en) begin
            if (mbox_push) begin
                last_msg_r <= i_pwdata[6:0];
            end
            if (do_push) begin
                fifo_mem_r[wr_ptr_r] <= i_pwdata[6:0];
                wr_ptr_r <= wr_ptr_r + {{(`FIFO_AW-1){1'b0}}, 1'b1};
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + {{(`FIFO_AW-1){1'b0}}, 1'b1};
            end
            if (local_pop) begin
                o_local_data <= head_vec;
            end
            local_pend_r <= (local_rd_fall | local_pend_r) & apb_pop & (level_r > 1);
            level_r <= level_nxt;
            o_local_interrupt_out <= (level_nxt != {(`FIFO_AW+1){1'b0}});
        end
    end

    // ====================================================================
    // Transmit command vector checks.
    wire cmd_is_init = (i_tx_command_field == `TXCMD_INIT);
    wire cmd_known = cmd_is_init | (i_tx_command_field == `TXCMD_OFF);
    // The threshold sum is deliberately not checked.
    wire cmd_fail = cmd_is_init & ((i_alloc_req > i_alloc_avail) |
                    (i_fwd_thr > i_buf_size) | (i_refill_thr > i_buf_size));
    wire cmd_emit = i_cmd_valid & cmd_known;

    wire [31:0] cmd_vec = {1'b1, `CMD_TX_TYPE, 9'h000, cmd_fail, ~cmd_fail,
                           8'h00, i_cmd_channel_number};

    // ====================================================================
    // Transmit event vectors and the hold abort path.
    wire tx_abort = i_tx_abort_cmd |
        (i_tx_next_offset_zero & ~i_tx_frame_end_flag & i_tx_prev_incomplete);
    wire tx_emit = i_tx_evt & (i_tx_host_initiated_flag | tx_abort);
    wire hold_emit = hold_pend_r & i_tx_data_done;

    wire [31:0] tx_vec = {1'b1, `TXEV_TYPE, i_tx_queue, 2'b00, i_tx_descriptor_tag,
                          i_tx_host_initiated_flag, tx_abort, 1'b0, 1'b0,
                          4'h0, i_tx_channel_number};
    wire [31:0] hold_vec = {1'b1, `TXEV_TYPE, hold_queue_r, 2'b00, hold_tag_r,
                            3'b000, 1'b1, 4'h0, hold_channel_number_r};

    wire any_emit = cmd_emit | tx_emit | hold_emit;
    wire vec_drop = (cmd_emit & (tx_emit | hold_emit)) | (tx_emit & hold_emit);

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_pend_r <= 1'b0;
            hold_channel_number_r <= 8'h00;
            hold_queue_r <= 3'h0;
            hold_tag_r <= 6'h00;
            o_vec_valid <= 1'b0;
            o_vec_data <= 32'h00000000;
            o_vec_queue <= 4'h0;
            o_append_abort <= 1'b0;
        end else if (i_clk_en) begin
            if (i_tx_fetch & i_tx_fetch_hold & ~i_tx_fetch_frame_end_flag) begin
                hold_pend_r <= 1'b1;
                hold_channel_number_r <= i_tx_channel_number;
                hold_queue_r <= i_tx_queue;
                hold_tag_r <= i_tx_descriptor_tag;
            end else if (hold_emit) begin
                hold_pend_r <= 1'b0;
            end
            o_append_abort <= hold_emit;
            o_vec_valid <= any_emit;
            if (cmd_emit) begin
                o_vec_data <= cmd_vec;
                o_vec_queue <= `CMD_QUEUE;
            end else if (hold_emit) begin
                o_vec_data <= hold_vec;
                o_vec_queue <= {1'b0, hold_queue_r};
            end else if (tx_emit) begin
                o_vec_data <= tx_vec;
                o_vec_queue <= {1'b0, i_tx_queue};
            end
        end
    end

    // ====================================================================
    // Interrupt status, mask and output; a set beats a same-cycle clear.
    wire irq_status_wr = apb_wr & (i_paddr == `REG_IRQ_STATUS);

    always @* begin
        irq_status_nxt = irq_status_r;
        if (irq_status_wr) begin
            irq_status_nxt = irq_status_r & ~i_pwdata[3:0];
        end
        if (do_push) begin
            irq_status_nxt[`ST_MBOX_PUSH] = 1'b1;
        end
        if (mbox_push & fifo_full) begin
            irq_status_nxt[`ST_FIFO_OVFL] = 1'b1;
        end
        if (cmd_emit & cmd_fail) begin
            irq_status_nxt[`ST_CMD_FAIL] = 1'b1;
        end
        if (vec_drop) begin
            irq_status_nxt[`ST_VEC_DROP] = 1'b1;
        end
    end

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_status_r <= 4'h0;
            irq_mask_r <= `IRQ_MASK_RESET;
            o_irq <= 1'b0;
        end else if (i_clk_en) begin
            irq_status_r <= irq_status_nxt;
            if (apb_wr & (i_paddr == `REG_IRQ_MASK)) begin
                irq_mask_r <= i_pwdata[3:0];
                o_irq <= |(irq_status_nxt & i_pwdata[3:0]);
            end else begin
                o_irq <= |(irq_status_nxt & irq_mask_r);
            end
        end
    end

endmodule // channel_number_irq_vectors

/* verification/channel_number_irq_vectors_asserts.sv */
/* Port checker for the channel interrupt vector builder.
   Assumes it is bound to channel_number_irq_vectors with i_clk_en held high. */
`timescale 1ns/100ps
module channel_number_irq_asserts (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Register bus
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic o_pready,
    // Events
    input wire logic i_tx_evt,
    input wire logic i_tx_host_initiated_flag,
    input wire logic [5:0] i_tx_descriptor_tag,
    input wire logic i_tx_data_done,
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_tx_command_field,
    input wire logic [7:0] i_cmd_channel_number,
    input wire logic [15:0] i_alloc_req,
    input wire logic [15:0] i_alloc_avail,
    // Vectors and local side
    input wire logic o_vec_valid,
    input wire logic [31:0] o_vec_data,
    input wire logic [3:0] o_vec_queue,
    input wire logic o_append_abort,
    input wire logic [15:0] o_local_data,
    input wire logic o_local_interrupt_out
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    chk_cmd_route: assert property (i_cmd_valid && i_tx_command_field inside {2'h1, 2'h2}
        |=> o_vec_valid && o_vec_queue == 4'h8 && o_vec_data[31:27] == 5'h12)
        else $error("command vector misrouted");
    chk_cmd_channel_number: assert property (i_cmd_valid && i_tx_command_field == 2'h1
        |=> o_vec_data[7:0] == $past(i_cmd_channel_number)) else $error("channel lost");
    chk_alloc_fail: assert property (i_cmd_valid && i_tx_command_field == 2'h1
        && i_alloc_req > i_alloc_avail |=> o_vec_data[17:16] == 2'h2) else $error("no fail");
    chk_tx_tag: assert property (i_tx_evt && i_tx_host_initiated_flag && !i_cmd_valid
        && !i_tx_data_done |=> o_vec_valid
        && o_vec_data[21:15] == {$past(i_tx_descriptor_tag), 1'h1}) else $error("tx tag");
    chk_hold_pair: assert property (o_append_abort |-> o_vec_valid && o_vec_data[12])
        else $error("abort without hold vector");
    chk_local_interrupt_out_push: assert property (i_psel && i_penable && o_pready && i_pwrite
        && i_paddr == 12'h000 |=> o_local_interrupt_out) else $error("no local interrupt");
    chk_mbox_form: assert property ($changed(o_local_data)
        |-> o_local_data[6:0] == 7'h60 && !o_local_data[14]) else $error("mailbox format");
    chk_last_local_interrupt_out: assert property ($changed(o_local_data)
        |-> o_local_data[15] != o_local_interrupt_out) else $error("last flag");
endmodule // channel_number_irq_asserts

bind channel_number_irq_vectors channel_number_irq_asserts i_channel_number_irq_asserts (.i_core_clk, .i_resetn, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .o_pready, .i_tx_evt, .i_tx_host_initiated_flag,
    .i_tx_descriptor_tag, .i_tx_data_done, .i_cmd_valid, .i_tx_command_field,
    .i_cmd_channel_number, .i_alloc_req, .i_alloc_avail, .o_vec_valid, .o_vec_data,
    .o_vec_queue, .o_append_abort, .o_local_data, .o_local_interrupt_out);

/* verification/local_cpu_model.sv */
/* Local processor that pops the interrupt FIFO over its read strobe.
   Assumes the strobe idles high under a pull-up. */
`timescale 1ns/100ps
module local_cpu_model (
    // Clock
    input wire logic i_core_clk,
    // Local bus
    input wire logic [15:0] i_local_data,
    output logic o_local_rd_n
);
    initial o_local_rd_n = 1'h1;
    // Pops one vector and returns it.
    task automatic read_vector(output logic [15:0] v);
        @(posedge i_core_clk);
        o_local_rd_n <= 1'h0;
        repeat (6) @(posedge i_core_clk);
        v = i_local_data;
        o_local_rd_n <= 1'h1;
        repeat (2) @(posedge i_core_clk);
    endtask
endmodule // local_cpu_model

/* verification/test_channel_interrupt_vectors_mailbox_fifo.sv */
/* Self-checking bench for the channel interrupt vector builder.
   Assumes the design, its checker and the local processor model. */
`timescale 1ns/100ps
module test_channel_interrupt_vectors_mailbox_fifo;
    logic i_core_clk = 1'h0, i_resetn = 1'h0, i_clk_en = 1'h1;
    logic i_psel, i_penable, i_pwrite, i_tx_evt, i_tx_host_initiated_flag, i_tx_abort_cmd;
    logic i_tx_next_offset_zero, i_tx_frame_end_flag, i_tx_prev_incomplete, i_tx_fetch;
    logic i_tx_fetch_hold, i_tx_fetch_frame_end_flag, i_tx_data_done, i_cmd_valid;
    logic [7:0] i_tx_channel_number, i_cmd_channel_number;
    logic [2:0] i_tx_queue;
    logic [5:0] i_tx_descriptor_tag;
    logic [1:0] i_tx_command_field;
    logic [15:0] i_alloc_req, i_alloc_avail, i_fwd_thr, i_refill_thr, i_buf_size, o_local_data;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, o_vec_data, r;
    logic [3:0] o_vec_queue;
    logic o_pready, o_pslverr, o_append_abort, o_vec_valid, o_local_interrupt_out, o_irq;
    logic i_local_rd_n, err;
    logic [15:0] v;
    logic [15:0] fw [6] = '{16'h2, 16'h2, 16'h9, 16'h2, 16'h8, 16'h2};
    logic [15:0] rf [6] = '{16'h3, 16'h3, 16'h3, 16'h9, 16'h8, 16'h3};
    logic fl [6] = '{1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    int n_mismatch = 0, samples_checked = 0;
    channel_number_irq_vectors i_channel_number_irq_vectors (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_tx_evt(i_tx_evt),
        .i_tx_channel_number(i_tx_channel_number), .i_tx_queue(i_tx_queue),
        .i_tx_descriptor_tag(i_tx_descriptor_tag),
        .i_tx_host_initiated_flag(i_tx_host_initiated_flag),
        .i_tx_abort_cmd(i_tx_abort_cmd), .i_tx_next_offset_zero(i_tx_next_offset_zero),
        .i_tx_frame_end_flag(i_tx_frame_end_flag),
        .i_tx_prev_incomplete(i_tx_prev_incomplete), .i_tx_fetch(i_tx_fetch),
        .i_tx_fetch_hold(i_tx_fetch_hold),
        .i_tx_fetch_frame_end_flag(i_tx_fetch_frame_end_flag),
        .i_tx_data_done(i_tx_data_done), .o_append_abort(o_append_abort),
        .i_cmd_valid(i_cmd_valid), .i_tx_command_field(i_tx_command_field),
        .i_cmd_channel_number(i_cmd_channel_number), .i_alloc_req(i_alloc_req),
        .i_alloc_avail(i_alloc_avail), .i_fwd_thr(i_fwd_thr), .i_refill_thr(i_refill_thr),
        .i_buf_size(i_buf_size), .o_vec_valid(o_vec_valid), .o_vec_data(o_vec_data),
        .o_vec_queue(o_vec_queue), .i_local_rd_n(i_local_rd_n),
        .o_local_data(o_local_data), .o_local_interrupt_out(o_local_interrupt_out),
        .o_irq(o_irq));
    local_cpu_model i_local_cpu_model (.i_core_clk, .i_local_data(o_local_data),
        .o_local_rd_n(i_local_rd_n));
    always #5 i_core_clk = ~i_core_clk;
    // ==========================================================
    // Shared tasks
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_core_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'h2, w, a, d};
        @(posedge i_core_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'h1 && n < 50);
        if (o_pready !== 1'h1) begin
            n_mismatch++;
            $display("wrong value at %0t: no bus answer", $time);
        end
        r = o_prdata;
        err = o_pslverr;
        {i_psel, i_penable} <= 2'h0;
    endtask
    task automatic get_vec(input logic [31:0] exp, input logic [3:0] q);
        int n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_vec_valid !== 1'h1 && n < 20);
        if (o_vec_valid !== 1'h1) begin
            n_mismatch++;
            $display("wrong value at %0t: no vector", $time);
        end
        check_word(o_vec_data, exp);
        check_word(o_vec_queue, q);
        err = o_append_abort;
    endtask
    function automatic logic [31:0] txv(input int q, input logic [2:0] f, input int c);
        return {5'h17, 3'(q), 2'h0, 6'(6'h2a + q), f[2:1], 1'h0, f[0], 4'h0, 8'(c)};
    endfunction
    // ==========================================================
    // Scenarios
    task automatic test_tx;
        for (int k = 0; k < 3; k++) begin
            @(posedge i_core_clk);
            {i_tx_channel_number, i_tx_queue, i_tx_descriptor_tag} <= {8'(8'h80 + k),
                3'(k), 6'(6'h2a + k)};
            {i_tx_host_initiated_flag, i_tx_abort_cmd} <= {k == 0, k == 1};
            {i_tx_next_offset_zero, i_tx_prev_incomplete, i_tx_evt} <= {k == 2, k == 2, 1'h1};
            @(posedge i_core_clk) i_tx_evt <= 1'h0;
            get_vec(txv(k, {k == 0, k != 0, 1'h0}, 8'h80 + k), 4'(k));
        end
        @(posedge i_core_clk);
        {i_tx_channel_number, i_tx_queue, i_tx_descriptor_tag} <= {8'h55, 3'h5, 6'h2f};
        {i_tx_fetch, i_tx_fetch_hold} <= 2'h3;
        @(posedge i_core_clk);
        {i_tx_fetch, i_tx_fetch_hold, i_tx_data_done, i_tx_channel_number} <= 11'h100;
        @(posedge i_core_clk) i_tx_data_done <= 1'h0;
        get_vec(txv(5, 3'h1, 8'h55), 4'h5);
        check_word(err, 32'h1);
        $display("test_tx done");
    endtask
    task automatic test_cmd;
        for (int k = 0; k < 6; k++) begin
            @(posedge i_core_clk);
            {i_cmd_valid, i_tx_command_field} <= {1'h1, (k == 5) ? 2'h2 : 2'h1};
            {i_cmd_channel_number, i_alloc_req} <= {8'(8'hc0 + k), (k == 1) ? 16'h5 : 16'h4};
            {i_fwd_thr, i_refill_thr, i_buf_size, i_alloc_avail} <= {fw[k], rf[k], 32'h80004};
            @(posedge i_core_clk) i_cmd_valid <= 1'h0;
            get_vec({5'h12, 9'h0, fl[k], ~fl[k], 8'h0, 8'(8'hc0 + k)}, 4'h8);
        end
        @(posedge i_core_clk);
        {i_cmd_valid, i_tx_command_field} <= {1'h1, 2'h3};
        @(posedge i_core_clk) i_cmd_valid <= 1'h0;
        @(posedge i_core_clk);
        check_word(o_vec_valid, 32'h0);
        apb(1'h0, 12'h00c, 32'h0);
        check_word(r, 32'h4);
        $display("test_cmd done");
    endtask
    task automatic test_mbox;
        for (int k = 1; k < 4; k++) apb(1'h1, 12'h000, 32'(k * 17));
        @(posedge i_core_clk);
        check_word(o_local_interrupt_out, 32'h1);
        check_word(o_irq, 32'h0);
        i_local_cpu_model.read_vector(v);
        check_word(v, {16'h0, 2'h0, 7'h11, 7'h60});
        apb(1'h0, 12'h004, 32'h0);
        check_word(r, {16'h0, 2'h0, 7'h22, 7'h60});
        i_local_cpu_model.read_vector(v);
        check_word(v, {16'h0, 2'h2, 7'h33, 7'h60});
        check_word(o_local_interrupt_out, 32'h0);
        apb(1'h1, 12'h010, 32'h1);
        @(posedge i_core_clk);
        check_word(o_irq, 32'h1);
        apb(1'h1, 12'h00c, 32'h1);
        repeat (2) @(posedge i_core_clk);
        check_word(o_irq, 32'h0);
        apb(1'h0, 12'h0f0, 32'h0);
        check_word({r[30:0], err}, 32'h1);
        $display("test_mbox done");
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        {i_psel, i_penable, i_pwrite, i_tx_evt, i_tx_host_initiated_flag, i_tx_abort_cmd,
            i_tx_next_offset_zero, i_tx_frame_end_flag, i_tx_prev_incomplete, i_tx_fetch,
            i_tx_fetch_hold, i_tx_fetch_frame_end_flag, i_tx_data_done, i_cmd_valid,
            i_tx_channel_number, i_cmd_channel_number, i_tx_queue, i_tx_descriptor_tag,
            i_tx_command_field, i_alloc_req, i_alloc_avail, i_fwd_thr, i_refill_thr,
            i_buf_size, i_paddr, i_pwdata} = '0;
        repeat (10) @(posedge i_core_clk);
        i_resetn <= 1'h1;
        test_tx;
        test_cmd;
        test_mbox;
        finish_test;
    end
    initial begin
        repeat (3000) @(posedge i_core_clk);
        n_mismatch++;
        finish_test;
    end
endmodule // test_channel_interrupt_vectors_mailbox_fifo
